// ==== acg_ch4_config.sv ====
// Channel 4 volume, fine gain, phase delay and shared ADC config registers
// with the datapath they steer.
// Assumes the control port decoder presents single-cycle read and write
// strobes on i_ref_clk, and that samples and modulator ticks share it.
`timescale 1ns/100ps
module acg_ch4_config #(
   parameter int DW = acg_pkg::DATA_W
) (
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_reset_n,
   input  wire logic                 i_reg_wr,
   input  wire logic                 i_reg_rd,
   input  wire logic        [7:0]    i_reg_addr,
   input  wire logic        [7:0]    i_reg_wdata,
   output logic             [7:0]    o_reg_rdata,
   input  wire logic                 i_ch4_valid,
   input  wire logic signed [DW-1:0] i_ch4_data,
   output logic                      o_ch4_valid,
   output logic signed      [DW-1:0] o_ch4_data,
   input  wire logic                 i_mod_tick,
   input  wire logic                 i_mod_bit,
   output logic                      o_mod_bit,
   output logic             [3:0]    o_cm_res_sel,
   output logic                      o_quant_offset_cal_enable
);
   logic [7:0] ch4_volume_code_r;
   logic [3:0] ch4_fine_gain_code_r;
   logic [5:0] ch4_phase_delay_cycles_r;
   logic [3:0] input_common_mode_trim_r;
   logic       quantizer_offset_cal_enable_r;
   logic       data_invert_r;
   logic [7:0] rd_mux;
   logic       first_r;

   logic       wr_vol, wr_fine, wr_phase, wr_shared;

   assign wr_vol    = i_reg_wr && (i_reg_addr == acg_pkg::OFS_VOLUME);
   assign wr_fine   = i_reg_wr && (i_reg_addr == acg_pkg::OFS_FINE_GAIN);
   assign wr_phase  = i_reg_wr && (i_reg_addr == acg_pkg::OFS_PHASE);
   assign wr_shared = i_reg_wr && (i_reg_addr == acg_pkg::OFS_SHARED);

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         ch4_volume_code_r <= acg_pkg::RST_VOLUME;                // R4
      else if (wr_vol)
         ch4_volume_code_r <= i_reg_wdata;                        // R14
   end

   // Only the writable field is stored, so reserved bits stay zero
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         ch4_fine_gain_code_r <=
            acg_pkg::RST_FINE_GAIN[acg_pkg::FINE_LSB +: 4];       // R6
      else if (wr_fine)
         ch4_fine_gain_code_r <= i_reg_wdata[acg_pkg::FINE_LSB +: 4];
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         ch4_phase_delay_cycles_r <=
            acg_pkg::RST_PHASE[acg_pkg::PHASE_LSB +: 6];          // R8
      else if (wr_phase)
         ch4_phase_delay_cycles_r <= i_reg_wdata[acg_pkg::PHASE_LSB +: 6];
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         input_common_mode_trim_r <=
            acg_pkg::RST_SHARED[acg_pkg::TRIM_LSB +: 4];          // R13
         quantizer_offset_cal_enable_r <=
            acg_pkg::RST_SHARED[acg_pkg::QCAL_BIT];
         data_invert_r <= acg_pkg::RST_SHARED[acg_pkg::INV_BIT];
      end else if (wr_shared) begin
         input_common_mode_trim_r <= i_reg_wdata[acg_pkg::TRIM_LSB +: 4];
         quantizer_offset_cal_enable_r <= i_reg_wdata[acg_pkg::QCAL_BIT];
         data_invert_r <= i_reg_wdata[acg_pkg::INV_BIT];
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      unique case (i_reg_addr)
         acg_pkg::OFS_VOLUME:    rd_mux = ch4_volume_code_r;
         acg_pkg::OFS_FINE_GAIN: rd_mux = {ch4_fine_gain_code_r, 4'h0}; // R12
         acg_pkg::OFS_PHASE:     rd_mux = {ch4_phase_delay_cycles_r, 2'h0};
         acg_pkg::OFS_SHARED:    rd_mux = {input_common_mode_trim_r,
                                           quantizer_offset_cal_enable_r,
                                           data_invert_r, 2'h0};
         default:                rd_mux = 8'h00;
      endcase
   end

   // Read data is held until the next read so the port can sample late
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         o_reg_rdata <= 8'h00;
      else if (i_reg_rd)
         o_reg_rdata <= rd_mux;                                   // R14
   end

   // Resistor selects follow the field bit for bit: one bit, one resistor
   assign o_cm_res_sel = input_common_mode_trim_r;                // R11
   assign o_quant_offset_cal_enable = quantizer_offset_cal_enable_r; // R10

   acg_gain_stage #(
      .DW (DW)
   ) u_gain (
      .i_ref_clk   (i_ref_clk),
      .i_reset_n   (i_reset_n),
      .i_valid     (i_ch4_valid),
      .i_data      (i_ch4_data),
      .i_vol_code  (ch4_volume_code_r),
      .i_fine_code (ch4_fine_gain_code_r),
      .i_invert    (data_invert_r),
      .o_valid     (o_ch4_valid),
      .o_data      (o_ch4_data)
   );

   acg_phase_delay #(
      .DEPTH (acg_pkg::PHASE_MAX)
   ) u_phase (
      .i_ref_clk  (i_ref_clk),
      .i_reset_n  (i_reset_n),
      .i_mod_tick (i_mod_tick),
      .i_mod_bit  (i_mod_bit),
      .i_delay    (ch4_phase_delay_cycles_r),
      .o_mod_bit  (o_mod_bit)
   );

   // Helper flag for the reset-value checks
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         first_r <= 1'b1;
      else
         first_r <= 1'b0;
   end

   localparam logic signed [DW-1:0] DMIN = {1'b1, {(DW-1){1'b0}}};

   property p_mute;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_ch4_valid && ch4_volume_code_r == acg_pkg::VOL_MUTE_CODE)
         |-> ##3 (o_ch4_valid && o_ch4_data == '0);
   endproperty
   a_mute: assert property (p_mute) // R1
      else $error("muted volume code let data through");

   property p_unity;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_ch4_valid && ch4_volume_code_r == acg_pkg::VOL_UNITY_CODE &&
       ch4_fine_gain_code_r == acg_pkg::FINE_UNITY && !data_invert_r)
         |-> ##3 (o_ch4_data == $past(i_ch4_data, 3));
   endproperty
   a_unity: assert property (p_unity) // R3
      else $error("unity settings changed the sample");

   property p_min_gain;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_ch4_valid && ch4_volume_code_r == acg_pkg::VOL_MIN_CODE &&
       ch4_fine_gain_code_r == acg_pkg::FINE_UNITY && !data_invert_r &&
       i_ch4_data >= 0)
         |-> ##3 (o_ch4_data <= ($past(i_ch4_data, 3) >>> 13) + 1);
   endproperty
   a_min_gain: assert property (p_min_gain) // R2
      else $error("lowest volume code not near -80 dB");

   property p_invert;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_ch4_valid && ch4_volume_code_r == acg_pkg::VOL_UNITY_CODE &&
       ch4_fine_gain_code_r == acg_pkg::FINE_UNITY && data_invert_r &&
       i_ch4_data != DMIN)
         |-> ##3 (o_ch4_data == -$past(i_ch4_data, 3));
   endproperty
   a_invert: assert property (p_invert) // R9
      else $error("inversion did not negate the sample");

   property p_reset_vals;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      first_r |-> (ch4_volume_code_r == acg_pkg::RST_VOLUME &&
                   ch4_fine_gain_code_r == acg_pkg::FINE_UNITY &&
                   ch4_phase_delay_cycles_r == 6'h00 &&
                   o_cm_res_sel == 4'h0 && !o_quant_offset_cal_enable &&
                   !data_invert_r);
   endproperty
   a_reset_vals: assert property (p_reset_vals) // R4
      else $error("register not at reset value after reset");

   property p_readback;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (wr_vol && !i_reg_rd) ##1 (i_reg_rd &&
         i_reg_addr == acg_pkg::OFS_VOLUME)
         |=> (o_reg_rdata == $past(i_reg_wdata, 2));
   endproperty
   a_readback: assert property (p_readback) // R14
      else $error("volume did not read back written value");

   property p_reserved;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_reg_rd && i_reg_addr == acg_pkg::OFS_FINE_GAIN)
         |=> (o_reg_rdata[3:0] == 4'h0);
   endproperty
   a_reserved: assert property (p_reserved) // R12
      else $error("reserved bits read nonzero");

   property p_zero_delay;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_mod_tick && ch4_phase_delay_cycles_r == 6'h00)
         |=> (o_mod_bit == $past(i_mod_bit));
   endproperty
   a_zero_delay: assert property (p_zero_delay) // R7
      else $error("zero phase setting added delay");

   property p_shared_ctrl;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      wr_shared |=> (o_cm_res_sel == $past(i_reg_wdata[7:4]) &&
         o_quant_offset_cal_enable == $past(i_reg_wdata[3]));
   endproperty
   a_shared_ctrl: assert property (p_shared_ctrl) // R11
      else $error("shared config write did not reach outputs");

   property p_unmapped;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_reg_rd && (i_reg_addr < acg_pkg::OFS_VOLUME ||
                    i_reg_addr > acg_pkg::OFS_SHARED))
         |=> (o_reg_rdata == 8'h00);
   endproperty
   a_unmapped: assert property (p_unmapped) // R12
      else $error("unmapped address read nonzero");

   // Read data must stand between reads, the port may sample late
   property p_rd_hold;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      !i_reg_rd |=> $stable(o_reg_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) // R14
      else $error("read data changed without a read");

   property p_fine_wr;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      wr_fine |=> (ch4_fine_gain_code_r == $past(i_reg_wdata[7:4]));
   endproperty
   a_fine_wr: assert property (p_fine_wr) // R5
      else $error("fine gain write not taken");

   property p_phase_wr;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      wr_phase |=> (ch4_phase_delay_cycles_r == $past(i_reg_wdata[7:2]));
   endproperty
   a_phase_wr: assert property (p_phase_wr) // R7
      else $error("phase delay write not taken");

   property p_invert_wr;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      wr_shared |=> (data_invert_r == $past(i_reg_wdata[2]));
   endproperty
   a_invert_wr: assert property (p_invert_wr) // R9
      else $error("invert bit write not taken");

   // The delayed bit may only move on a modulator tick
   property p_mod_hold;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      !i_mod_tick |=> $stable(o_mod_bit);
   endproperty
   a_mod_hold: assert property (p_mod_hold) // R7
      else $error("delayed bit moved without a tick");

   property p_cov_collide;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      i_reg_wr && i_reg_rd;
   endproperty
   c_cov_collide: cover property (p_cov_collide);

   property p_cov_mute;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      wr_vol && i_reg_wdata == acg_pkg::VOL_MUTE_CODE;
   endproperty
   c_cov_mute: cover property (p_cov_mute);

   property p_cov_invert;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      o_ch4_valid && data_invert_r;
   endproperty
   c_cov_invert: cover property (p_cov_invert);

   property p_cov_max_delay;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      i_mod_tick && ch4_phase_delay_cycles_r == 6'h3f;
   endproperty
   c_cov_max_delay: cover property (p_cov_max_delay);
endmodule

// ==== acg_pkg.sv ====
// Constants shared by the channel 4 gain, phase and shared ADC config block.
// Assumes every user runs on the control-interface clock i_ref_clk.
// Function
// [R1] Volume code zero mutes the channel 4 digital output completely.
// [R2] Volume code 1 is -80 dB and each further code adds half a decibel.
// [R3] Volume code 161 is unity gain and code 255 is the top boost of 47 dB.
// [R4] The volume register resets to 0xa1, which is unity gain.
// [R5] Fine gain bits 7..4 trim in 0.1 dB steps, code 8 being 0 dB.
// [R6] The fine gain register resets to 0x80, which is 0 dB.
// [R7] Phase bits 7..2 delay the channel by that many modulator cycles.
// [R8] The phase field resets to zero, so no delay is added after reset.
// [R9] Shared config bit 2 inverts the ADC output data.
// [R10] Shared config bit 3 puts the quantizer into offset calibration.
// [R11] Shared config bits 7..4 drive the common-mode resistor selects.
// [R12] Software writes reserved bits as zero and they always read zero.
// [R13] The shared config register resets to 0x00, everything inactive.
// [R14] Fields read back what was written and act with no commit step.
package acg_pkg;
   localparam logic [7:0] OFS_VOLUME     = 8'h5f;
   localparam logic [7:0] OFS_FINE_GAIN  = 8'h60;
   localparam logic [7:0] OFS_PHASE      = 8'h61;
   localparam logic [7:0] OFS_SHARED     = 8'h62;

   localparam logic [7:0] RST_VOLUME     = 8'ha1;
   localparam logic [7:0] RST_FINE_GAIN  = 8'h80;
   localparam logic [7:0] RST_PHASE      = 8'h00;
   localparam logic [7:0] RST_SHARED     = 8'h00;

   localparam int FINE_LSB   = 4;
   localparam int PHASE_LSB  = 2;
   localparam int TRIM_LSB   = 4;
   localparam int QCAL_BIT   = 3;
   localparam int INV_BIT    = 2;

   localparam logic [7:0] VOL_MUTE_CODE  = 8'h00;
   localparam logic [7:0] VOL_MIN_CODE   = 8'h01;
   localparam logic [7:0] VOL_UNITY_CODE = 8'ha1;
   localparam logic [3:0] FINE_UNITY     = 4'h8;

   // Code plus 7 counts half-dB steps above -84 dB, 12 to each 6 dB octave
   localparam logic [8:0] VOL_OCT_OFS    = 9'h007;
   localparam logic [8:0] VOL_STEPS_OCT  = 9'h00c;
   localparam logic [4:0] VOL_OCT_UNITY  = 5'h0e;
   localparam int         GAIN_FRAC      = 14;

   // Half-dB mantissas within one octave, Q2.14
   localparam logic [15:0] VOL_MANT [12] = '{
      16'h4000, 16'h43cb, 16'h47cf, 16'h4c10, 16'h5092, 16'h5558,
      16'h5a67, 16'h5fc2, 16'h656f, 16'h6b72, 16'h71d0, 16'h788e};

   // Fine gain -0.8 dB .. +0.7 dB, Q2.14
   localparam logic [15:0] FINE_MANT [16] = '{
      16'h3a5f, 16'h3b0c, 16'h3bba, 16'h3c6c, 16'h3d1e, 16'h3dd4,
      16'h3e8b, 16'h3f45, 16'h4000, 16'h40be, 16'h417e, 16'h4240,
      16'h4304, 16'h43cb, 16'h4494, 16'h455f};

   localparam int PHASE_MAX  = 63;
   localparam int DATA_W     = 24;
endpackage

// ==== acg_gain_stage.sv ====
// Three-stage volume, fine gain, saturation and inversion pipeline.
// Assumes samples and settings arrive on i_ref_clk; settings are
// captured with the sample so a write mid-pipeline never splits a sample.
`timescale 1ns/100ps
module acg_gain_stage #(
   parameter int DW = acg_pkg::DATA_W
) (
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_reset_n,
   input  wire logic                 i_valid,
   input  wire logic signed [DW-1:0] i_data,
   input  wire logic        [7:0]    i_vol_code,
   input  wire logic        [3:0]    i_fine_code,
   input  wire logic                 i_invert,
   output logic                      o_valid,
   output logic signed      [DW-1:0] o_data
);
   localparam int EW = DW + 10;
   localparam logic signed [EW-1:0] SMAX =
      {{(EW-DW+1){1'b0}}, {(DW-1){1'b1}}};
   localparam logic signed [EW-1:0] SMIN =
      {{(EW-DW+1){1'b1}}, {(DW-1){1'b0}}};
   localparam logic signed [DW-1:0] DMAX = {1'b0, {(DW-1){1'b1}}};
   localparam logic signed [DW-1:0] DMIN = {1'b1, {(DW-1){1'b0}}};

   logic        [8:0]       vol_ofs;
   logic        [4:0]       oct_c;
   logic        [3:0]       rem_c;
   logic signed [DW+16:0]   p1;
   logic signed [DW+17:0]   p2;
   logic signed [EW-1:0]    ext;
   logic signed [EW-1:0]    shifted;
   logic signed [DW-1:0]    sat;

   logic                    v1_r, v2_r;
   logic signed [DW:0]      s1_r;
   logic signed [DW+1:0]    s2_r;
   logic        [3:0]       fine1_r;
   logic        [4:0]       oct1_r, oct2_r;
   logic                    mute1_r, mute2_r, inv1_r, inv2_r;

   // Coarse step split into octave and half-dB remainder
   assign vol_ofs = {1'b0, i_vol_code} + acg_pkg::VOL_OCT_OFS;   // R2
   assign oct_c   = 5'(vol_ofs / acg_pkg::VOL_STEPS_OCT);       // R3
   assign rem_c   = 4'(vol_ofs % acg_pkg::VOL_STEPS_OCT);
   assign p1 = i_data * $signed({1'b0, acg_pkg::VOL_MANT[rem_c]});
   assign p2 = s1_r * $signed({1'b0, acg_pkg::FINE_MANT[fine1_r]}); // R5

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         v1_r    <= 1'b0;
         s1_r    <= '0;
         fine1_r <= acg_pkg::FINE_UNITY;
         oct1_r  <= acg_pkg::VOL_OCT_UNITY;
         mute1_r <= 1'b0;
         inv1_r  <= 1'b0;
      end else begin
         v1_r    <= i_valid;
         s1_r    <= p1[DW+14:14];
         fine1_r <= i_fine_code;
         oct1_r  <= oct_c;
         mute1_r <= (i_vol_code == acg_pkg::VOL_MUTE_CODE);  // R1
         inv1_r  <= i_invert;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         v2_r    <= 1'b0;
         s2_r    <= '0;
         oct2_r  <= acg_pkg::VOL_OCT_UNITY;
         mute2_r <= 1'b0;
         inv2_r  <= 1'b0;
      end else begin
         v2_r    <= v1_r;
         s2_r    <= p2[DW+15:14];
         oct2_r  <= oct1_r;
         mute2_r <= mute1_r;
         inv2_r  <= inv1_r;
      end
   end

   // Each octave is taken as 6 dB; the 0.02 dB per octave drift is
   // the price of a shift instead of a full exponent table
   always_comb begin
      ext = {{8{s2_r[DW+1]}}, s2_r};
      if (oct2_r >= acg_pkg::VOL_OCT_UNITY)
         shifted = ext <<< (oct2_r - acg_pkg::VOL_OCT_UNITY);     // R3
      else
         shifted = ext >>> (acg_pkg::VOL_OCT_UNITY - oct2_r);     // R2
      if (shifted > SMAX)
         sat = DMAX;
      else if (shifted < SMIN)
         sat = DMIN;
      else
         sat = shifted[DW-1:0];
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_valid <= 1'b0;
         o_data  <= '0;
      end else begin
         o_valid <= v2_r;
         if (mute2_r)
            o_data <= '0;                                         // R1
         else if (inv2_r)
            o_data <= (sat == DMIN) ? DMAX : -sat;                // R9
         else
            o_data <= sat;
      end
   end
endmodule

// ==== acg_phase_delay.sv ====
// Programmable delay of the modulator bit stream in modulator cycles.
// Assumes i_mod_tick is a one-cycle strobe per modulator cycle from logic
// on i_ref_clk, so no synchroniser is needed.
`timescale 1ns/100ps
module acg_phase_delay #(
   parameter int DEPTH = acg_pkg::PHASE_MAX
) (
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset_n,
   input  wire logic       i_mod_tick,
   input  wire logic       i_mod_bit,
   input  wire logic [5:0] i_delay,
   output logic            o_mod_bit
);
   logic [DEPTH-1:0] hist_r;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         hist_r <= '0;
      else if (i_mod_tick)
         hist_r <= {hist_r[DEPTH-2:0], i_mod_bit};
   end

   // Delay read straight from the live setting, no commit needed
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         o_mod_bit <= 1'b0;
      else if (i_mod_tick) begin
         if (i_delay == 6'h00)
            o_mod_bit <= i_mod_bit;                               // R8
         else
            o_mod_bit <= hist_r[i_delay - 6'h01];                 // R7
      end
   end
endmodule

// ==== acg_ch4_config_tb.sv ====
// Self-checking bench for the channel 4 gain, phase and shared config block.
// Assumes the block's own assertions are compiled in with the design files.
`timescale 1ns/100ps
module acg_ch4_config_tb;
   localparam int TIME_LIMIT = 20000;
   logic               ref_clk;
   logic               reset_n;
   logic               reg_wr;
   logic               reg_rd;
   logic        [7:0]  reg_addr;
   logic        [7:0]  reg_wdata;
   logic        [7:0]  reg_rdata;
   logic               ch4_valid;
   logic signed [23:0] ch4_data;
   logic               ch4_valid_o;
   logic signed [23:0] ch4_data_o;
   logic               mod_tick;
   logic               mod_bit;
   logic               mod_bit_o;
   logic        [3:0]  cm_res_sel;
   logic               qcal_en;
   int                 n_fail;
   int                 comparisons;
   int                 cycles;
   logic        [7:0]  rd;
   logic        [23:0] q;

   acg_ch4_config #(.DW(24)) dut (
      .i_ref_clk                 (ref_clk),
      .i_reset_n                 (reset_n),
      .i_reg_wr                  (reg_wr),
      .i_reg_rd                  (reg_rd),
      .i_reg_addr                (reg_addr),
      .i_reg_wdata               (reg_wdata),
      .o_reg_rdata               (reg_rdata),
      .i_ch4_valid               (ch4_valid),
      .i_ch4_data                (ch4_data),
      .o_ch4_valid               (ch4_valid_o),
      .o_ch4_data                (ch4_data_o),
      .i_mod_tick                (mod_tick),
      .i_mod_bit                 (mod_bit),
      .o_mod_bit                 (mod_bit_o),
      .o_cm_res_sel              (cm_res_sel),
      .o_quant_offset_cal_enable (qcal_en)
   );

   initial ref_clk = 1'b0;
   always #10 ref_clk = ~ref_clk;

   task automatic give_verdict();
      $display("Checks made: %0d, mismatches: %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // A hang counts as a mismatch so the verdict cannot pass silently
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == TIME_LIMIT) begin
         n_fail = n_fail + 1;
         give_verdict();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic near(input logic [23:0] v, input int e,
                                 input int tol);
      logic signed [31:0] d;
      d = $signed({{8{v[23]}}, v}) - e;
      return (d <= tol) && (d >= -tol);
   endfunction

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Waits a bounded time for the output strobe; latency is three edges
   task automatic send(input logic signed [23:0] d, output logic [23:0] r);
      int n;
      // The edge that takes the sample counts as the first
      n = 1;
      @(posedge ref_clk);
      ch4_valid <= 1'b1;
      ch4_data  <= d;
      @(posedge ref_clk);
      ch4_valid <= 1'b0;
      #1;
      while (ch4_valid_o !== 1'b1 && n < 8) begin
         @(posedge ref_clk);
         #1 n = n + 1;
      end
      chk("sample_latency", n, 3);
      r = ch4_data_o;
   endtask

   task automatic tick(input logic b);
      @(posedge ref_clk);
      mod_tick <= 1'b1;
      mod_bit  <= b;
      @(posedge ref_clk);
      mod_tick <= 1'b0;
      #1;
   endtask

   task automatic t_reset_vals();
      rd_reg(acg_pkg::OFS_VOLUME, rd);
      chk("volume_rst", rd, 8'ha1);
      rd_reg(acg_pkg::OFS_FINE_GAIN, rd);
      chk("fine_rst", rd, 8'h80);
      rd_reg(acg_pkg::OFS_PHASE, rd);
      chk("phase_rst", rd, 8'h00);
      rd_reg(acg_pkg::OFS_SHARED, rd);
      chk("shared_rst", rd, 8'h00);
      chk("cm_rst", cm_res_sel, 4'h0);
      chk("qcal_rst", qcal_en, 1'b0);
   endtask

   task automatic t_regs();
      logic [7:0] adr [4];
      logic [7:0] msk [4];
      adr = '{8'h5f, 8'h60, 8'h61, 8'h62};
      msk = '{8'hff, 8'hf0, 8'hfc, 8'hfc};
      for (int i = 0; i < 4; i++) begin
         wr_reg(adr[i], 8'hff);
         rd_reg(adr[i], rd);
         chk("rw_ones", rd, msk[i]);
         wr_reg(adr[i], 8'h5a);
         rd_reg(adr[i], rd);
         chk("rw_pat", rd, 8'h5a & msk[i]);
      end
      wr_reg(8'h63, 8'h55);
      rd_reg(8'h63, rd);
      chk("unmapped", rd, 8'h00);
      wr_reg(8'h5f, 8'ha1);
      wr_reg(8'h60, 8'h80);
      wr_reg(8'h61, 8'h00);
      wr_reg(8'h62, 8'h00);
   endtask

   task automatic t_shared();
      logic [3:0] codes [4];
      codes = '{4'h1, 4'h2, 4'h4, 4'h8};
      for (int i = 0; i < 4; i++) begin
         wr_reg(8'h62, {codes[i], 4'h0});
         #1 chk("cm_sel", cm_res_sel, codes[i]);
         chk("qcal_off", qcal_en, 1'b0);
      end
      wr_reg(8'h62, 8'h08);
      #1 chk("qcal_on", qcal_en, 1'b1);
      chk("cm_none", cm_res_sel, 4'h0);
      wr_reg(8'h62, 8'h00);
      #1 chk("qcal_clr", qcal_en, 1'b0);
   endtask

   task automatic t_gain();
      send(24'sh123456, q);
      chk("unity", q, 24'h123456);
      send(-24'sh400000, q);
      chk("unity_neg", q, 24'hc00000);
      wr_reg(8'h5f, 8'h00);
      send(24'sh3fffff, q);
      chk("mute", q, 24'h000000);
      wr_reg(8'h5f, 8'h01);
      send(24'sh7fffff, q);
      chk("min_gain", near(q, 839, 64), 1'b1);
      wr_reg(8'h5f, 8'd173);
      send(24'sd1000, q);
      chk("six_db", q, 24'd2000);
      wr_reg(8'h5f, 8'd162);
      send(24'sd1000, q);
      chk("half_db", near(q, 1059, 2), 1'b1);
      wr_reg(8'h5f, 8'hff);
      send(24'sd1000, q);
      chk("max_gain", near(q, 223872, 4000), 1'b1);
      send(24'sh100000, q);
      chk("sat_pos", q, 24'h7fffff);
      send(-24'sh100000, q);
      chk("sat_neg", q, 24'h800000);
      wr_reg(8'h5f, 8'ha1);
      wr_reg(8'h60, 8'h00);
      send(24'sd16384, q);
      chk("fine_lo", near(q, 14944, 40), 1'b1);
      wr_reg(8'h60, 8'hf0);
      send(24'sd16384, q);
      chk("fine_hi", near(q, 17760, 40), 1'b1);
      wr_reg(8'h60, 8'h80);
      send(24'sd16384, q);
      chk("fine_unity", q, 24'd16384);
   endtask

   task automatic t_invert();
      wr_reg(8'h62, 8'h04);
      send(24'sd1000, q);
      chk("inv", q, 24'hfffc18);
      send(-24'sh800000, q);
      chk("inv_min", q, 24'h7fffff);
      wr_reg(8'h62, 8'h00);
      send(24'sd1000, q);
      chk("no_inv", q, 24'd1000);
   endtask

   task automatic t_phase();
      int   dly [3];
      logic hist [70];
      tick(1'b1);
      chk("no_delay_1", mod_bit_o, 1'b1);
      tick(1'b0);
      chk("no_delay_0", mod_bit_o, 1'b0);
      dly = '{1, 5, 63};
      for (int j = 0; j < 3; j++) begin
         wr_reg(8'h61, 8'(dly[j] << 2));
         for (int k = 0; k < 70; k++) begin
            hist[k] = ((k % 3) == 0) ^ ((k % 7) < 3);
            tick(hist[k]);
            if (k >= dly[j])
               chk("delayed_bit", mod_bit_o, hist[k-dly[j]]);
         end
      end
   endtask

   // Write then read on the next edge, then a read that meets a write
   task automatic t_b2b();
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= 8'h5f;
      reg_wdata <= 8'h3c;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_wdata <= 8'ha1;
      #1 chk("wr_then_rd", reg_rdata, 8'h3c);
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      #1 chk("rd_meets_wr", reg_rdata, 8'h3c);
      rd_reg(8'h5f, rd);
      chk("after_meet", rd, 8'ha1);
   endtask

   task automatic t_rereset();
      wr_reg(8'h5f, 8'h10);
      wr_reg(8'h62, 8'hf4);
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_reset_vals();
   endtask

   initial begin
      n_fail      = 0;
      comparisons = 0;
      cycles      = 0;
      reset_n     = 1'b0;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      reg_addr    = 8'h00;
      reg_wdata   = 8'h00;
      ch4_valid   = 1'b0;
      ch4_data    = 24'sh000000;
      mod_tick    = 1'b0;
      mod_bit     = 1'b0;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_reset_vals();
      t_phase();
      t_regs();
      t_b2b();
      t_shared();
      t_gain();
      t_invert();
      t_rereset();
      give_verdict();
   end
endmodule
